// ===== common/scr_pkg.sv
/*
  Shared constants of the sensor command and response unit: register offsets,
  status fields, command codes, response codes, parameter indices and reset values.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
package scr_pkg;

  // ----------------------------------------------------------------------
  // Register map and status fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_COMMAND = 8'h00;
  localparam logic [7:0] REG_RESPONSE = 8'h04;
  localparam logic [7:0] REG_PARAM_IN = 8'h08;
  localparam logic [7:0] REG_PARAM_OUT = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_LOOP_PROX_BIT = 1;
  localparam int ST_LOOP_AMB_BIT = 2;
  localparam int ST_ADDR_LSB = 8;

  // ----------------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] OP_FETCH = 3'h4;
  localparam logic [2:0] OP_STORE = 3'h5;
  localparam logic [7:0] CMD_RESP_CLEAR = 8'h00;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h01;
  localparam logic [7:0] CMD_ADDR_CHANGE = 8'h02;
  localparam logic [7:0] CMD_PROX_SHOT = 8'h05;
  localparam logic [7:0] CMD_AMB_SHOT = 8'h06;
  localparam logic [7:0] CMD_BOTH_SHOT = 8'h07;
  localparam logic [7:0] CMD_PROX_HALT = 8'h09;
  localparam logic [7:0] CMD_AMB_HALT = 8'h0A;
  localparam logic [7:0] CMD_BOTH_HALT = 8'h0B;
  localparam logic [7:0] CMD_RSVD_ACK = 8'h0C;
  localparam logic [7:0] CMD_PROX_START = 8'h0D;
  localparam logic [7:0] CMD_AMB_START = 8'h0E;
  localparam logic [7:0] CMD_BOTH_START = 8'h0F;

  // ----------------------------------------------------------------------
  // Response codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] RESP_RST = 8'h00;
  localparam logic [7:0] RESP_INVALID = 8'h80;
  localparam logic [7:0] PROX_ONE_OVERRANGE_CODE = 8'h88;
  localparam logic [7:0] PROX_TWO_OVERRANGE_CODE = 8'h89;
  localparam logic [7:0] PROX_THREE_OVERRANGE_CODE = 8'h8A;
  localparam logic [7:0] VISIBLE_OVERRANGE_CODE = 8'h8C;
  localparam logic [7:0] INFRARED_OVERRANGE_CODE = 8'h8D;
  localparam logic [7:0] AUX_OVERRANGE_CODE = 8'h8E;

  // ----------------------------------------------------------------------
  // Parameter store, channel list and channels
  // ----------------------------------------------------------------------
  localparam logic [4:0] PIDX_SLAVE_ADDR = 5'h00;
  localparam logic [4:0] PIDX_CHAN_LIST = 5'h01;
  localparam logic [4:0] PIDX_WAKE_INT = 5'h08;
  localparam int LIST_PROX_LSB = 0;
  localparam int LIST_AMB_LSB = 4;
  localparam logic [2:0] PROX_CHAN_ONE = 3'h0;
  localparam logic [2:0] PROX_CHAN_TWO = 3'h1;
  localparam logic [2:0] PROX_CHAN_THREE = 3'h2;
  localparam logic [2:0] VISIBLE_LIGHT_CHAN = 3'h3;
  localparam logic [2:0] INFRARED_LIGHT_CHAN = 3'h4;
  localparam logic [2:0] AUX_CHAN = 3'h5;
  localparam logic [7:0] PARAM_RST = 8'h00;
  // Arbitrary neutral value
  localparam logic [6:0] SLAVE_ADDR_RST = 7'h2A;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_PICK, ST_WAIT} scr_state_t;

endpackage : scr_pkg

// ===== design/scr_param_ram.sv
/*
  Parameter store of the sequencer: flip-flop entries with one write port,
  one indexed read port and fixed taps for the channel list and wake interval.
  Assumes write and clear come from logic on the same clock.
*/
`timescale 1ns/100ps
module scr_param_ram #(
  parameter int DW = 8,
  parameter int DEPTH = 32
) (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  // Access
  input wire logic clr,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata,
  // Fixed taps
  output logic [DW-1:0] list_q,
  output logic [DW-1:0] wake_q
);

  logic [DW-1:0] mem_r [DEPTH];

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < DEPTH; g++) begin : g_ent
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        mem_r[g] <= scr_pkg::PARAM_RST;
      end else if (ce && clr) begin
        mem_r[g] <= scr_pkg::PARAM_RST;
      end else if (ce && we && addr == g) begin
        mem_r[g] <= wdata;
      end
    end
  end

  assign rdata = mem_r[addr];
  assign list_q = mem_r[scr_pkg::PIDX_CHAN_LIST];
  assign wake_q = mem_r[scr_pkg::PIDX_WAKE_INT];

endmodule : scr_param_ram

// ===== design/scr_cmd_unit.sv
/*
  Command decoder and response mailbox of the sensor sequencer, reached over
  classic Wishbone. Drives a measurement datapath by request and done handshake.
  Assumes meas_done and meas_overflow come from logic on ref_clk; wake_clk is a
  slow free running pin that paces the autonomous loops.
*/
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
module scr_cmd_unit (
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  // Wishbone slave
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  // Measurement datapath
  output logic meas_req,
  output logic [2:0] meas_chan,
  input wire logic meas_done,
  input wire logic meas_overflow,
  // Wake time base pin and bus address
  input wire logic wake_clk,
  output logic [6:0] slave_addr
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [2:0] first_set(input logic [5:0] m);
    first_set = 3'h0;
    for (int i = 5; i >= 0; i--) begin
      if (m[i]) begin
        first_set = 3'(i);
      end
    end
  endfunction : first_set

  function automatic logic [7:0] ovf_code(input logic [2:0] ch);
    case (ch)
      scr_pkg::PROX_CHAN_ONE: ovf_code = scr_pkg::PROX_ONE_OVERRANGE_CODE;
      scr_pkg::PROX_CHAN_TWO: ovf_code = scr_pkg::PROX_TWO_OVERRANGE_CODE;
      scr_pkg::PROX_CHAN_THREE: ovf_code = scr_pkg::PROX_THREE_OVERRANGE_CODE;
      scr_pkg::VISIBLE_LIGHT_CHAN: ovf_code = scr_pkg::VISIBLE_OVERRANGE_CODE;
      scr_pkg::INFRARED_LIGHT_CHAN: ovf_code = scr_pkg::INFRARED_OVERRANGE_CODE;
      default: ovf_code = scr_pkg::AUX_OVERRANGE_CODE;
    endcase
  endfunction : ovf_code

  scr_pkg::scr_state_t state_r, state_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [7:0] resp_r, resp_nxt;
  logic [7:0] param_in_r, param_in_nxt;
  logic [7:0] param_out_r, param_out_nxt;
  logic [6:0] addr_r, addr_nxt;
  logic loop_ps_r, loop_ps_nxt, loop_als_r, loop_als_nxt;
  logic auto_r, auto_nxt;
  logic [5:0] pend_r, pend_nxt;
  logic req_r, req_nxt;
  logic [2:0] chan_r, chan_nxt;
  logic wk_s1, wk_s2, wk_s3;
  logic [7:0] wake_cnt_r, wake_cnt_nxt;
  logic [7:0] ram_rdata, list_q, wake_q;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire req = wb_cyc && wb_stb;
  wire wr_take = req && wb_we && ack_r && wb_sel[0];
  wire cmd_wr = wr_take && wb_adr == scr_pkg::REG_COMMAND;
  wire pin_wr = wr_take && wb_adr == scr_pkg::REG_PARAM_IN;
  wire idle = state_r == scr_pkg::ST_IDLE;
  wire exec = state_r == scr_pkg::ST_EXEC;
  wire pick = state_r == scr_pkg::ST_PICK;
  wire waiting = state_r == scr_pkg::ST_WAIT;
  // A command written while busy is dropped; status busy tells software why
  wire cmd_go = cmd_wr && idle;
  wire [31:0] status_w = {17'h0, addr_r, 5'h0, loop_als_r, loop_ps_r, !idle};

  assign ack_nxt = req && !ack_r;
  assign dat_nxt = !(req && !ack_r) ? dat_r :
                   wb_adr == scr_pkg::REG_COMMAND ? {24'h0, cmd_r} :
                   wb_adr == scr_pkg::REG_RESPONSE ? {24'h0, resp_r} :
                   wb_adr == scr_pkg::REG_PARAM_IN ? {24'h0, param_in_r} :
                   wb_adr == scr_pkg::REG_PARAM_OUT ? {24'h0, param_out_r} :
                   wb_adr == scr_pkg::REG_STATUS ? status_w : 32'h0;
  assign cmd_nxt = cmd_go ? wb_dat_w[7:0] : cmd_r;
  assign param_in_nxt = pin_wr ? wb_dat_w[7:0] : param_in_r;

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  wire op_fetch = cmd_r[7:5] == scr_pkg::OP_FETCH;
  wire op_store = cmd_r[7:5] == scr_pkg::OP_STORE;
  wire c_clear = cmd_r == scr_pkg::CMD_RESP_CLEAR;
  wire c_sreset = cmd_r == scr_pkg::CMD_SOFT_RESET;
  wire c_addr = cmd_r == scr_pkg::CMD_ADDR_CHANGE;
  wire c_ps_shot = cmd_r == scr_pkg::CMD_PROX_SHOT || cmd_r == scr_pkg::CMD_BOTH_SHOT;
  wire c_als_shot = cmd_r == scr_pkg::CMD_AMB_SHOT || cmd_r == scr_pkg::CMD_BOTH_SHOT;
  wire c_shot = c_ps_shot || c_als_shot;
  wire c_ps_halt = cmd_r == scr_pkg::CMD_PROX_HALT || cmd_r == scr_pkg::CMD_BOTH_HALT;
  wire c_als_halt = cmd_r == scr_pkg::CMD_AMB_HALT || cmd_r == scr_pkg::CMD_BOTH_HALT;
  wire c_ps_start = cmd_r == scr_pkg::CMD_PROX_START || cmd_r == scr_pkg::CMD_BOTH_START;
  wire c_als_start = cmd_r == scr_pkg::CMD_AMB_START || cmd_r == scr_pkg::CMD_BOTH_START;
  // Reserved codes other than CMD_RSVD_ACK fall through every term below and touch nothing
  wire c_count = op_fetch || op_store || c_ps_halt || c_als_halt || c_ps_start ||
                 c_als_start || cmd_r == scr_pkg::CMD_RSVD_ACK;

  wire [2:0] prox_en = list_q[scr_pkg::LIST_PROX_LSB +: 3];
  wire [2:0] amb_en = list_q[scr_pkg::LIST_AMB_LSB +: 3];
  wire [4:0] ram_addr = (op_fetch || op_store) ? cmd_r[4:0] : scr_pkg::PIDX_SLAVE_ADDR;
  wire ram_we = exec && op_store;
  wire ram_clr = exec && c_sreset;

  scr_param_ram #(.DW(8), .DEPTH(32)) u_ram (
    .ref_clk(ref_clk),
    .reset(reset),
    .ce(ce),
    .clr(ram_clr),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(param_in_r),
    .rdata(ram_rdata),
    .list_q(list_q),
    .wake_q(wake_q)
  );

  // ----------------------------------------------------------------------
  // Autonomous wake time base
  // ----------------------------------------------------------------------
  wire wake_edge = wk_s2 && !wk_s3;
  wire [7:0] wake_inc = 8'(wake_cnt_r + 8'h01);
  wire forced_only = wake_q == 8'h00;
  wire wake_tick = wake_edge && !forced_only && wake_inc >= wake_q;
  // A tick that lands while a pass runs is skipped rather than queued
  wire auto_go = idle && !cmd_go && wake_tick && (loop_ps_r || loop_als_r);
  assign wake_cnt_nxt = forced_only ? 8'h00 : wake_tick ? 8'h00 :
                        wake_edge ? wake_inc : wake_cnt_r;

  // ----------------------------------------------------------------------
  // Loops, pass mask and measurement handshake
  // ----------------------------------------------------------------------
  assign loop_ps_nxt = ram_clr ? 1'b0 : (exec && c_ps_halt) ? 1'b0 :
                       (exec && c_ps_start) ? 1'b1 : loop_ps_r;
  assign loop_als_nxt = ram_clr ? 1'b0 : (exec && c_als_halt) ? 1'b0 :
                        (exec && c_als_start) ? 1'b1 : loop_als_r;

  wire [5:0] shot_mask = {c_als_shot ? amb_en : 3'h0, c_ps_shot ? prox_en : 3'h0};
  wire [5:0] auto_mask = {loop_als_r ? amb_en : 3'h0, loop_ps_r ? prox_en : 3'h0};
  wire [5:0] done_bit = 6'(6'h01 << chan_r);
  wire meas_end = waiting && meas_done;
  assign pend_nxt = (exec && c_shot) ? shot_mask :
                    auto_go ? auto_mask :
                    meas_end ? (pend_r & ~done_bit) : pend_r;
  assign auto_nxt = auto_go ? 1'b1 : cmd_go ? 1'b0 : auto_r;
  // Lowest pending bit first gives proximity one to three, then ambient order
  assign chan_nxt = (pick && pend_r != 6'h0) ? first_set(pend_r) :
                    chan_r;
  assign req_nxt = (pick && pend_r != 6'h0) ? 1'b1 : meas_end ? 1'b0 : req_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      scr_pkg::ST_IDLE: begin
        if (cmd_go) begin
          state_nxt = scr_pkg::ST_EXEC;
        end else if (auto_go) begin
          state_nxt = scr_pkg::ST_PICK;
        end
      end
      scr_pkg::ST_EXEC: state_nxt = c_shot ? scr_pkg::ST_PICK : scr_pkg::ST_IDLE;
      scr_pkg::ST_PICK: begin
        state_nxt = (pend_r == 6'h0) ? scr_pkg::ST_IDLE : scr_pkg::ST_WAIT;
      end
      scr_pkg::ST_WAIT: state_nxt = meas_done ? scr_pkg::ST_PICK : scr_pkg::ST_WAIT;
      default: state_nxt = scr_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // Mailboxes, address and response
  // ----------------------------------------------------------------------
  assign param_out_nxt = (exec && op_fetch) ? ram_rdata :
                         (exec && op_store) ? param_in_r : param_out_r;
  wire addr_bad = ram_rdata[7];
  assign addr_nxt = ram_clr ? scr_pkg::SLAVE_ADDR_RST :
                    (exec && c_addr && !addr_bad) ? ram_rdata[6:0] : addr_r;

  wire clr_pulse = exec && (c_clear || c_sreset);
  wire comp_pulse = (exec && c_count) || (pick && pend_r == 6'h0 && !auto_r);
  wire err_set = (exec && c_addr && addr_bad) || (meas_end && meas_overflow);
  wire [7:0] err_code = exec ? scr_pkg::RESP_INVALID : ovf_code(chan_r);
  // First error sticks; later completions and errors leave it until cleared
  assign resp_nxt = clr_pulse ? scr_pkg::RESP_RST :
                    (err_set && !resp_r[7]) ? err_code :
                    (comp_pulse && resp_r[7:4] == 4'h0) ? {4'h0, 4'(resp_r[3:0] + 4'h1)} :
                    resp_r;

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      {wk_s1, wk_s2, wk_s3} <= 3'h0;
    end else if (ce) begin
      {wk_s1, wk_s2, wk_s3} <= {wake_clk, wk_s1, wk_s2};
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= scr_pkg::ST_IDLE;
      ack_r <= 1'b0;
      dat_r <= 32'h0;
      cmd_r <= 8'h00;
      param_in_r <= scr_pkg::PARAM_RST;
      param_out_r <= scr_pkg::PARAM_RST;
    end else if (ce) begin
      state_r <= state_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      cmd_r <= cmd_nxt;
      param_in_r <= param_in_nxt;
      param_out_r <= param_out_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      resp_r <= scr_pkg::RESP_RST;
      addr_r <= scr_pkg::SLAVE_ADDR_RST;
      {loop_ps_r, loop_als_r, auto_r, req_r} <= 4'h0;
      pend_r <= 6'h0;
      chan_r <= 3'h0;
      wake_cnt_r <= 8'h00;
    end else if (ce) begin
      resp_r <= resp_nxt;
      addr_r <= addr_nxt;
      {loop_ps_r, loop_als_r, auto_r, req_r} <= {loop_ps_nxt, loop_als_nxt, auto_nxt, req_nxt};
      pend_r <= pend_nxt;
      chan_r <= chan_nxt;
      wake_cnt_r <= wake_cnt_nxt;
    end
  end

  assign wb_ack = ack_r;
  assign wb_dat_r = dat_r;
  assign meas_req = req_r;
  assign meas_chan = chan_r;
  assign slave_addr = addr_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_clear_zero;
    @(posedge ref_clk) disable iff (reset)
      ce && exec && c_clear |=> resp_r == 8'h00;
  endproperty
  a_clear_zero: assert property (p_clear_zero)
    else $error("clear did not zero response");

  property p_count_inc;
    @(posedge ref_clk) disable iff (reset)
      ce && comp_pulse && !clr_pulse && !err_set && resp_r[7:4] == 4'h0
      |=> resp_r == {4'h0, 4'($past(resp_r[3:0]) + 4'h1)};
  endproperty
  a_count_inc: assert property (p_count_inc)
    else $error("counter not incremented");

  property p_err_hold;
    @(posedge ref_clk) disable iff (reset)
      resp_r[7] && !(ce && clr_pulse) |=> $stable(resp_r);
  endproperty
  a_err_hold: assert property (p_err_hold) else $error("error code lost");

  property p_fetch;
    @(posedge ref_clk) disable iff (reset)
      ce && exec && op_fetch |=> param_out_r == $past(ram_rdata);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch value missing");

  property p_store_echo;
    @(posedge ref_clk) disable iff (reset)
      ce && exec && op_store |=> param_out_r == $past(param_in_r) ##1 ram_rdata == param_out_r;
  endproperty
  a_store_echo: assert property (p_store_echo) else $error("store or echo wrong");

  property p_order;
    @(posedge ref_clk) disable iff (reset)
      $rose(meas_req) |-> pend_r[chan_r] && (pend_r & 6'(done_bit - 6'h01)) == 6'h0;
  endproperty
  a_order: assert property (p_order) else $error("channel out of order");

  property p_forced;
    @(posedge ref_clk) disable iff (reset)
      ce && forced_only && idle && !cmd_go |=> idle;
  endproperty
  a_forced: assert property (p_forced) else $error("woke without command");

  property p_halt;
    @(posedge ref_clk) disable iff (reset)
      ce && exec && cmd_r == scr_pkg::CMD_BOTH_HALT |=> !loop_ps_r && !loop_als_r;
  endproperty
  a_halt: assert property (p_halt) else $error("loops still running");

  property p_prox_ovf;
    @(posedge ref_clk) disable iff (reset)
      ce && meas_end && meas_overflow && !resp_r[7] && chan_r == scr_pkg::PROX_CHAN_TWO
      |=> resp_r == 8'h89;
  endproperty
  a_prox_ovf: assert property (p_prox_ovf) else $error("wrong proximity code");

  property p_amb_ovf;
    @(posedge ref_clk) disable iff (reset)
      ce && meas_end && meas_overflow && !resp_r[7] && chan_r == scr_pkg::AUX_CHAN
      |=> resp_r == 8'h8E;
  endproperty
  a_amb_ovf: assert property (p_amb_ovf) else $error("wrong ambient code");

  property p_addr;
    @(posedge ref_clk) disable iff (reset)
      ce && exec && c_addr && !addr_bad |=> slave_addr == $past(ram_rdata[6:0]);
  endproperty
  a_addr: assert property (p_addr) else $error("address not changed");

  property p_shot_end;
    @(posedge ref_clk) disable iff (reset)
      ce && pick && pend_r == 6'h0 |=> idle && !meas_req;
  endproperty
  a_shot_end: assert property (p_shot_end) else $error("pass did not end");

  c_fetch: cover property (@(posedge ref_clk) disable iff (reset) exec && op_fetch);
  c_both: cover property (@(posedge ref_clk) disable iff (reset)
    exec && cmd_r == scr_pkg::CMD_BOTH_SHOT ##[1:200] pick && pend_r == 6'h0);
  c_ovf: cover property (@(posedge ref_clk) disable iff (reset) meas_end && meas_overflow);
  c_auto: cover property (@(posedge ref_clk) disable iff (reset) auto_go);

endmodule : scr_cmd_unit

// ===== tb/scr_meas_model.sv
/*
  Measurement datapath model: answers each held request with one done pulse.
  Assumes requests on ref_clk, held until done; latency and overflow set by the bench.
*/
`timescale 1ns/100ps
module scr_meas_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Request link
  input wire logic meas_req,
  input wire logic [2:0] meas_chan,
  input wire logic [2:0] lat,
  input wire logic [3:0] ovf_chan,
  output logic meas_done,
  output logic meas_overflow
);
  logic armed_r;
  logic fired_r;
  logic [2:0] wait_r;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      {armed_r, fired_r, wait_r, meas_done, meas_overflow} <= '0;
    end else begin
      meas_done <= 1'b0;
      meas_overflow <= 1'b0;
      // Rearm only once the request drops, so one request gets one pulse
      if (!meas_req) begin
        armed_r <= 1'b0;
        fired_r <= 1'b0;
      end else if (!armed_r) begin
        armed_r <= 1'b1;
        wait_r <= lat;
      end else if (wait_r != 3'h0) begin
        wait_r <= wait_r - 3'h1;
      end else if (!fired_r) begin
        meas_done <= 1'b1;
        meas_overflow <= (ovf_chan == {1'b0, meas_chan});
        fired_r <= 1'b1;
      end
    end
  end
endmodule : scr_meas_model

// ===== tb/test_sensor_command_response_unit.sv
/*
  Self-checking bench of the command unit with a datapath model.
  Assumes the package and design files are compiled first.
*/
`timescale 1ns/100ps
module test_sensor_command_response_unit;
  logic ref_clk = 0, reset = 1, wake_clk = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0;
  logic wb_ack, meas_req, meas_done, meas_ovf, req_q = 0;
  logic [7:0] wb_adr = 0, v, idx;
  logic [3:0] wb_sel = 0, ovf_chan = 7, cnt;
  logic [31:0] wb_dat_w = 0, wb_dat_r, rd;
  logic [2:0] meas_chan, lat = 1;
  logic [6:0] slave_addr;
  logic [23:0] seen;
  int fails = 0, samples_checked = 0, nseen = 0, n0, seed = 32;
  always #4 ref_clk = ~ref_clk;
  always #80 wake_clk = ~wake_clk;
  scr_cmd_unit dut_u (.ref_clk(ref_clk), .reset(reset), .ce(1'b1), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
    .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .meas_req(meas_req), .meas_chan(meas_chan),
    .meas_done(meas_done), .meas_overflow(meas_ovf), .wake_clk(wake_clk),
    .slave_addr(slave_addr));
  scr_meas_model far_u (.ref_clk(ref_clk), .reset(reset), .meas_req(meas_req),
    .meas_chan(meas_chan), .lat(lat), .ovf_chan(ovf_chan), .meas_done(meas_done),
    .meas_overflow(meas_ovf));
  always @(posedge ref_clk) begin
    req_q <= meas_req;
    if (meas_req && !req_q) begin
      seen <= {seen[20:0], meas_chan};
      nseen <= nseen + 1;
    end
  end
  function automatic logic [23:0] order(input logic [7:0] c, input logic [7:0] l);
    logic [23:0] s;
    s = 24'h0;
    for (int i = 0; i < 7; i++)
      if (i != 3 && l[i] && c[i / 4]) s = {s[20:0], 3'(i - i / 4)};
    return s;
  endfunction : order
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hF;
    wb_dat_w <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 40);
    chk(32'(n < 40), 1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge ref_clk);
  endtask : xfer
  task automatic cmd(input logic [7:0] c);
    int n;
    n = 0;
    // Write clear of any loop pass: a write while busy would be dropped
    @(posedge wake_clk);
    repeat (18) @(posedge ref_clk);
    xfer(1, scr_pkg::REG_COMMAND, {24'h0, c});
    do begin
      xfer(0, scr_pkg::REG_STATUS, 0);
      n++;
    end while (rd[0] !== 1'b0 && n < 200);
    chk(32'(n < 200), 1);
  endtask : cmd
  task automatic rsp(input logic [7:0] e);
    xfer(0, scr_pkg::REG_RESPONSE, 0);
    chk(rd, {24'h0, e});
  endtask : rsp
  task automatic put(input logic [4:0] a, input logic [7:0] d);
    xfer(1, scr_pkg::REG_PARAM_IN, {24'h0, d});
    cmd({3'b101, a});
    cnt++;
  endtask : put
  // Full host handshake: clear, check zero, command, repeat while still zero
  task automatic hs(input logic [7:0] c);
    int k;
    k = 0;
    do begin
      cmd(8'h00);
      rsp(8'h00);
      cmd(c);
      xfer(0, scr_pkg::REG_RESPONSE, 0);
      k++;
    end while (rd[7:0] === 8'h00 && k < 3);
    chk(32'(k), 1);
  endtask : hs
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rsp(8'h00);
    chk(32'(slave_addr), 32'(scr_pkg::SLAVE_ADDR_RST));
    xfer(0, 8'h20, 0);
    chk(rd, 0);
    cnt = 0;
    repeat (4) begin
      v = 8'($random(seed));
      idx = 8'h02 + 8'($random(seed) & 3);
      put(idx[4:0], v);
      rsp({4'h0, cnt});
      xfer(0, scr_pkg::REG_PARAM_OUT, 0);
      chk(rd, {24'h0, v});
      put(idx[4:0] + 5'h08, ~v);
      cmd({3'b100, idx[4:0]});
      cnt++;
      xfer(0, scr_pkg::REG_PARAM_OUT, 0);
      chk(rd, {24'h0, v});
      rsp({4'h0, cnt});
    end
    cmd(8'h00);
    cnt = 4'h1;
    repeat (17) cmd(8'h0C);
    rsp(8'h01);
    for (int c = 3; c < 32; c++)
      if (c == 3 || c == 4 || c == 8 || c > 15) begin
        cmd(8'(c));
        rsp({4'h0, cnt});
      end
    for (int c = 5; c < 8; c++) begin
      v = 8'($random(seed)) & 8'h77;
      put(5'h01, v);
      lat = 3'($random(seed));
      seen = 24'h0;
      cmd(8'(c));
      cnt++;
      chk(32'(seen), 32'(order(8'(c), v)));
      rsp({4'h0, cnt});
    end
    put(5'h01, 8'h77);
    for (int k = 0; k < 6; k++) begin
      ovf_chan = 4'(k);
      hs(8'h07);
      chk(rd, (k < 3) ? 32'(8'h88 + k) : 32'(8'h89 + k));
    end
    cmd(8'h0C);
    rsp(8'h8E);
    ovf_chan = 4'h7;
    cmd(8'h00);
    cnt = 4'h0;
    v = 8'($random(seed)) & 8'h7F;
    put(5'h00, v);
    cmd(8'h02);
    chk(32'(slave_addr), 32'(v));
    put(5'h00, v | 8'h80);
    cmd(8'h02);
    cmd(8'h0C);
    rsp(8'h80);
    cmd(8'h01);
    rsp(8'h00);
    chk(32'(slave_addr), 32'(scr_pkg::SLAVE_ADDR_RST));
    cnt = 4'h0;
    lat = 3'h0;
    put(5'h01, 8'h11);
    put(5'h08, 8'h03);
    // Starting one loop leaves the other running, so the loop bits accumulate
    for (int c = 13; c < 16; c++) begin
      cmd(8'(c));
      cnt++;
      xfer(0, scr_pkg::REG_STATUS, 0);
      chk(32'(rd[2:1]), (c == 13) ? 1 : 3);
      n0 = nseen;
      repeat (400) @(posedge ref_clk);
      chk(32'(nseen > n0), 1);
    end
    cmd(8'h0B);
    cnt++;
    n0 = nseen;
    repeat (400) @(posedge ref_clk);
    chk(32'(nseen), 32'(n0));
    put(5'h08, 8'h00);
    cmd(8'h0F);
    cnt++;
    n0 = nseen;
    repeat (400) @(posedge ref_clk);
    chk(32'(nseen), 32'(n0));
    rsp({4'h0, cnt});
    wrap_up();
  end
endmodule : test_sensor_command_response_unit
